// ### tmc_top.sv
// Purpose: Operating-mode control and supplementary configuration
// Assumes: Pins asynchronous to CLK_SYS_I, slow next to 4 ns clock
// Notes: Mode strobe doubles as the serial frame enable
//
// Notes on behaviour
// - Mode inputs only matter while strobe low
// - Mode applied at strobe rising edge
// - 000 sleep all off; 001 oscillator only
// - 100 receive: oscillator, synthesizer, baseband, receiver
// - 111 transmit: oscillator, synthesizer, transmitter
// - 010 enables oscillator and baseband only
// - 011 adds synthesizer to oscillator, baseband
// - 110 enables oscillator and synthesizer only
// - Boost setting zero selects stepped sequence
// - Map bit zero: 10/20/40/200 kHz
// - Map bit one: 14.3/28.5/66.7/100 kHz
// - Cut-off code 000..111: 660 Hz..10.2 kHz
// - Reset to standby; first edge adopts mode

module tmc_top (
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic [2:0] MODE_I,
    input wire logic EN_N_I,
    input wire logic SCK_I,
    input wire logic SI_I,
    output logic SO_O,
    output logic SO_OE_O,
    output logic [2:0] MODE_O,
    output logic XOSC_EN_O,
    output logic SYNTH_EN_O,
    output logic BASEBAND_EN_O,
    output logic RX_EN_O,
    output logic TX_EN_O,
    output logic STEPPED_SEQ_O,
    output logic [11:0] BB_BW_O,
    output logic [9:0] HPF_CUTOFF_O
);

    // ------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------
    function automatic logic [4:0] mode_enables(input logic [2:0] m);
        logic [4:0] e;
        e = '0;
        case (m)
            tmc_pkg::MODE_SLEEP: begin
                e = '0;
            end
            tmc_pkg::MODE_STANDBY: begin
                e[tmc_pkg::EN_XOSC] = 1'b1;
            end
            tmc_pkg::MODE_RX_STEP1: begin
                e[tmc_pkg::EN_XOSC] = 1'b1;
                e[tmc_pkg::EN_BB] = 1'b1;
            end
            tmc_pkg::MODE_RX_STEP2: begin
                e[tmc_pkg::EN_XOSC] = 1'b1;
                e[tmc_pkg::EN_SYNTH] = 1'b1;
                e[tmc_pkg::EN_BB] = 1'b1;
            end
            tmc_pkg::MODE_RX: begin
                e[tmc_pkg::EN_XOSC] = 1'b1;
                e[tmc_pkg::EN_SYNTH] = 1'b1;
                e[tmc_pkg::EN_BB] = 1'b1;
                e[tmc_pkg::EN_RX] = 1'b1;
            end
            tmc_pkg::MODE_TX_STEP: begin
                e[tmc_pkg::EN_XOSC] = 1'b1;
                e[tmc_pkg::EN_SYNTH] = 1'b1;
            end
            tmc_pkg::MODE_TX: begin
                e[tmc_pkg::EN_XOSC] = 1'b1;
                e[tmc_pkg::EN_SYNTH] = 1'b1;
                e[tmc_pkg::EN_TX] = 1'b1;
            end
            default: begin
                // Undefined code: keep only the oscillator, as in standby
                e[tmc_pkg::EN_XOSC] = 1'b1;
            end
        endcase
        return e;
    endfunction

    function automatic logic [11:0] bw_decode(input logic map_alt, input logic [1:0] code);
        logic [11:0] v;
        v = '0;
        case ({map_alt, code})
            3'h0: v = tmc_pkg::BW_STD_0;
            3'h1: v = tmc_pkg::BW_STD_1;
            3'h2: v = tmc_pkg::BW_STD_2;
            3'h3: v = tmc_pkg::BW_STD_3;
            3'h4: v = tmc_pkg::BW_ALT_0;
            3'h5: v = tmc_pkg::BW_ALT_1;
            3'h6: v = tmc_pkg::BW_ALT_2;
            3'h7: v = tmc_pkg::BW_ALT_3;
            default: v = tmc_pkg::BW_STD_0;
        endcase
        return v;
    endfunction

    function automatic logic [9:0] hpf_decode(input logic [2:0] code);
        logic [9:0] v;
        v = '0;
        case (code)
            3'h0: v = tmc_pkg::HPF_0;
            3'h1: v = tmc_pkg::HPF_1;
            3'h2: v = tmc_pkg::HPF_2;
            3'h3: v = tmc_pkg::HPF_3;
            3'h4: v = tmc_pkg::HPF_4;
            3'h5: v = tmc_pkg::HPF_5;
            3'h6: v = tmc_pkg::HPF_6;
            3'h7: v = tmc_pkg::HPF_7;
            default: v = tmc_pkg::HPF_0;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [5:0] pins_s;
    logic [2:0] mode_s;
    logic en_n_s;
    logic sck_s;
    logic si_s;

    // Strobe idles high after reset so no false edge is seen
    tmc_sync #(.W(6)) u_sync (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RST_N_I),
        .d_i({MODE_I, EN_N_I, SCK_I, SI_I}),
        .rst_val_i(6'h04),
        .q_o(pins_s)
    );

    assign mode_s = pins_s[5:3];
    assign en_n_s = pins_s[2];
    assign sck_s = pins_s[1];
    assign si_s = pins_s[0];

    logic en_n_d_ff;
    logic sck_d_ff;
    logic en_rise;
    logic sck_rise;
    logic sck_fall;

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            en_n_d_ff <= 1'b1;
            sck_d_ff <= 1'b0;
        end else begin
            en_n_d_ff <= en_n_s;
            sck_d_ff <= sck_s;
        end
    end

    assign en_rise = en_n_s & ~en_n_d_ff;
    assign sck_rise = sck_s & ~sck_d_ff & ~en_n_s;
    assign sck_fall = ~sck_s & sck_d_ff & ~en_n_s;

    // ------------------------------------------------------------
    // Mode latch
    // ------------------------------------------------------------
    logic [2:0] mode_ff;
    logic [4:0] enables_ff;

    // Mode pins are sampled only on the strobe's rising edge
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mode_ff <= tmc_pkg::MODE_RESET;
            enables_ff <= 5'h10;
        end else if (en_rise) begin
            mode_ff <= mode_s;
            enables_ff <= mode_enables(mode_s);
        end
    end

    // ------------------------------------------------------------
    // Serial register port
    // ------------------------------------------------------------
    logic [3:0] bit_cnt_ff;
    logic [13:0] shift_ff;
    logic [7:0] bw_map_ff;
    logic [7:0] hpf_ff;
    logic [7:0] rx_param_ff;
    logic [7:0] rd_shift_ff;
    logic rd_active_ff;
    logic so_ff;
    logic so_oe_ff;
    logic [14:0] frame;
    logic [4:0] rd_addr;
    logic wr_hit;
    logic rd_hit;

    assign frame = {shift_ff, si_s};
    assign rd_addr = frame[4:0];
    assign wr_hit = sck_rise && (bit_cnt_ff == tmc_pkg::LAST_BIT_CNT) && !frame[14] && !frame[13];
    assign rd_hit = sck_rise && (bit_cnt_ff == tmc_pkg::ADDR_DONE_CNT) && !frame[6] && frame[5];

    function automatic logic [7:0] read_mux(input logic [4:0] a, input logic [7:0] bw,
                                            input logic [7:0] hp, input logic [7:0] rp,
                                            input logic [2:0] m);
        logic [7:0] d;
        d = '0;
        case (a)
            tmc_pkg::ADDR_BW_MAP: d = bw;
            tmc_pkg::ADDR_HPF: d = hp;
            tmc_pkg::ADDR_RX_PARAM: d = rp;
            tmc_pkg::ADDR_STATUS: d = {5'h00, m};
            default: d = '0;
        endcase
        return d;
    endfunction

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            bit_cnt_ff <= '0;
            shift_ff <= '0;
        end else if (en_n_s) begin
            bit_cnt_ff <= '0;
            shift_ff <= '0;
        end else if (sck_rise && bit_cnt_ff != tmc_pkg::FRAME_BITS) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            shift_ff <= frame[13:0];
        end
    end

    // Writes commit on the last data bit, before the strobe rises
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            bw_map_ff <= tmc_pkg::REG_RESET;
            hpf_ff <= tmc_pkg::REG_RESET;
            rx_param_ff <= tmc_pkg::REG_RESET;
        end else if (wr_hit) begin
            case (frame[12:8])
                tmc_pkg::ADDR_BW_MAP: bw_map_ff <= frame[7:0];
                tmc_pkg::ADDR_HPF: hpf_ff <= frame[7:0];
                tmc_pkg::ADDR_RX_PARAM: rx_param_ff <= frame[7:0];
                default: begin
                end
            endcase
        end
    end

    // Read data leaves on falling clock, MSB first
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rd_shift_ff <= '0;
            rd_active_ff <= 1'b0;
            so_ff <= 1'b0;
            so_oe_ff <= 1'b0;
        end else if (en_n_s) begin
            rd_active_ff <= 1'b0;
            so_ff <= 1'b0;
            so_oe_ff <= 1'b0;
        end else if (rd_hit) begin
            rd_shift_ff <= read_mux(rd_addr, bw_map_ff, hpf_ff, rx_param_ff, mode_ff);
            rd_active_ff <= 1'b1;
        end else if (sck_fall && rd_active_ff) begin
            so_ff <= rd_shift_ff[7];
            so_oe_ff <= 1'b1;
            rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // Decoded configuration outputs
    // ------------------------------------------------------------
    logic [11:0] bb_bw_ff;
    logic [9:0] hpf_cut_ff;
    logic stepped_ff;

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            bb_bw_ff <= tmc_pkg::BW_STD_0;
            hpf_cut_ff <= tmc_pkg::HPF_0;
            stepped_ff <= 1'b1;
        end else begin
            bb_bw_ff <= bw_decode(bw_map_ff[tmc_pkg::BW_MAP_BIT],
                                  rx_param_ff[tmc_pkg::BW_CODE_MSB:tmc_pkg::BW_CODE_LSB]);
            hpf_cut_ff <= hpf_decode(hpf_ff[tmc_pkg::HPF_MSB:tmc_pkg::HPF_LSB]);
            stepped_ff <= ~rx_param_ff[tmc_pkg::WBB_BIT];
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign SO_O = so_ff;
    assign SO_OE_O = so_oe_ff;
    assign MODE_O = mode_ff;
    assign XOSC_EN_O = enables_ff[tmc_pkg::EN_XOSC];
    assign SYNTH_EN_O = enables_ff[tmc_pkg::EN_SYNTH];
    assign BASEBAND_EN_O = enables_ff[tmc_pkg::EN_BB];
    assign RX_EN_O = enables_ff[tmc_pkg::EN_RX];
    assign TX_EN_O = enables_ff[tmc_pkg::EN_TX];
    assign STEPPED_SEQ_O = stepped_ff;
    assign BB_BW_O = bb_bw_ff;
    assign HPF_CUTOFF_O = hpf_cut_ff;

endmodule

// ### tmc_pkg.sv
// Purpose: Constants for the transceiver mode control block
// Assumes: 5-bit register addresses, 8-bit register data
// Notes: Frequencies kept in 100 Hz and 10 Hz units

package tmc_pkg;

    // ------------------------------------------------------------
    // Mode codes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_SLEEP = 3'h0;
    localparam logic [2:0] MODE_STANDBY = 3'h1;
    localparam logic [2:0] MODE_RX_STEP1 = 3'h2;
    localparam logic [2:0] MODE_RX_STEP2 = 3'h3;
    localparam logic [2:0] MODE_RX = 3'h4;
    localparam logic [2:0] MODE_UNDEF = 3'h5;
    localparam logic [2:0] MODE_TX_STEP = 3'h6;
    localparam logic [2:0] MODE_TX = 3'h7;
    localparam logic [2:0] MODE_RESET = MODE_STANDBY;

    // Enable vector bit positions
    localparam int EN_XOSC = 4;
    localparam int EN_SYNTH = 3;
    localparam int EN_BB = 2;
    localparam int EN_RX = 1;
    localparam int EN_TX = 0;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_BW_MAP = 5'h13;
    localparam logic [4:0] ADDR_HPF = 5'h16;
    localparam logic [4:0] ADDR_RX_PARAM = 5'h1D;
    localparam logic [4:0] ADDR_STATUS = 5'h1E;
    localparam logic [7:0] REG_RESET = 8'h00;

    localparam int BW_MAP_BIT = 2;
    localparam int HPF_LSB = 3;
    localparam int HPF_MSB = 5;
    localparam int BW_CODE_LSB = 0;
    localparam int BW_CODE_MSB = 1;
    localparam int WBB_BIT = 2;

    // ------------------------------------------------------------
    // Serial frame: start, rw, 5 address bits, 8 data bits
    // ------------------------------------------------------------
    localparam logic [3:0] FRAME_BITS = 4'hF;
    localparam logic [3:0] ADDR_DONE_CNT = 4'h6;
    localparam logic [3:0] LAST_BIT_CNT = 4'hE;

    // ------------------------------------------------------------
    // Bandwidth values in 100 Hz units
    // ------------------------------------------------------------
    localparam logic [11:0] BW_STD_0 = 12'h064;
    localparam logic [11:0] BW_STD_1 = 12'h0C8;
    localparam logic [11:0] BW_STD_2 = 12'h190;
    localparam logic [11:0] BW_STD_3 = 12'h7D0;
    localparam logic [11:0] BW_ALT_0 = 12'h08F;
    localparam logic [11:0] BW_ALT_1 = 12'h11D;
    localparam logic [11:0] BW_ALT_2 = 12'h29B;
    localparam logic [11:0] BW_ALT_3 = 12'h3E8;

    // ------------------------------------------------------------
    // High-pass cut-off values in 10 Hz units
    // ------------------------------------------------------------
    localparam logic [9:0] HPF_0 = 10'h042;
    localparam logic [9:0] HPF_1 = 10'h094;
    localparam logic [9:0] HPF_2 = 10'h0AF;
    localparam logic [9:0] HPF_3 = 10'h0C4;
    localparam logic [9:0] HPF_4 = 10'h0FF;
    localparam logic [9:0] HPF_5 = 10'h14E;
    localparam logic [9:0] HPF_6 = 10'h1FF;
    localparam logic [9:0] HPF_7 = 10'h3FC;

endpackage

// ### tmc_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs asynchronous to CLK
// Notes: Only the second stage is visible outside

module tmc_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    input wire logic [W-1:0] rst_val_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // Idle value shown until the chain holds real pin samples
    logic primed_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
            primed_ff <= 1'b0;
        end else begin
            meta_ff <= d_i;
            primed_ff <= 1'b1;
            sync_ff <= primed_ff ? meta_ff : rst_val_i;
        end
    end

    // Idle value also during reset, so no false strobe edge follows it
    assign q_o = primed_ff ? sync_ff : rst_val_i;

endmodule

// ### tmc_top_chk.sv
// Purpose: Mode strobe and enable checks for tmc_top
// Assumes: Pins change just after CLK_SYS_I rising edges
// Notes: Enable vector is {xosc, synth, bb, rx, tx}
module tmc_top_chk (
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic [2:0] MODE_I,
    input wire logic EN_N_I,
    input wire logic [2:0] MODE_O,
    input wire logic XOSC_EN_O,
    input wire logic SYNTH_EN_O,
    input wire logic BASEBAND_EN_O,
    input wire logic RX_EN_O,
    input wire logic TX_EN_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] en_vec;
    logic en_q_ff;
    logic [2:0] since_rise_ff;
    assign en_vec = {XOSC_EN_O, SYNTH_EN_O, BASEBAND_EN_O, RX_EN_O, TX_EN_O};
    // Saturating count, so a stale strobe never excuses a late change
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            en_q_ff <= 1'b1;
            since_rise_ff <= 3'h7;
        end else begin
            en_q_ff <= EN_N_I;
            if (EN_N_I && !en_q_ff) begin
                since_rise_ff <= 3'h0;
            end else if (since_rise_ff != 3'h7) begin
                since_rise_ff <= since_rise_ff + 3'h1;
            end
        end
    end
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);
    sequence strobe_rise_s;
        !EN_N_I ##1 EN_N_I [*3];
    endsequence
    mode_apply_a: assert property (strobe_rise_s |-> ##[0:2] (MODE_O == MODE_I))
        else $error("mode not applied after strobe rise");
    no_early_a: assert property ($changed(MODE_O) |-> since_rise_ff <= 3'h4)
        else $error("mode changed away from a strobe rise");
    sleep_off_a: assert property (MODE_O == 3'h0 |-> en_vec == 5'h00)
        else $error("sleep enables wrong");
    standby_osc_a: assert property (MODE_O == 3'h1 |-> en_vec == 5'h10)
        else $error("standby enables wrong");
    rx_first_a: assert property (MODE_O == 3'h2 |-> en_vec == 5'h14)
        else $error("code 010 enables wrong");
    rx_second_a: assert property (MODE_O == 3'h3 |-> en_vec == 5'h1C)
        else $error("code 011 enables wrong");
    rx_mode_a: assert property (MODE_O == 3'h4 |-> en_vec == 5'h1E)
        else $error("receive enables wrong");
    tx_prep_a: assert property (MODE_O == 3'h6 |-> en_vec == 5'h18)
        else $error("code 110 enables wrong");
    tx_mode_a: assert property (MODE_O == 3'h7 |-> en_vec == 5'h19)
        else $error("transmit enables wrong");
endmodule

bind tmc_top tmc_top_chk tmc_top_chk_i (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .MODE_I(MODE_I),
    .EN_N_I(EN_N_I), .MODE_O(MODE_O), .XOSC_EN_O(XOSC_EN_O), .SYNTH_EN_O(SYNTH_EN_O),
    .BASEBAND_EN_O(BASEBAND_EN_O), .RX_EN_O(RX_EN_O), .TX_EN_O(TX_EN_O));

// ### tmc_host_model.sv
// Purpose: Host controller driving mode pins and serial frames
// Assumes: Serial frame is start, rw, addr[4:0], data[7:0]
// Notes: Serial clock stands low between frames
module tmc_host_model (
    input wire logic clk_i,
    input wire logic so_i,
    output logic [2:0] mode_o,
    output logic en_n_o,
    output logic sck_o,
    output logic si_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        mode_o = 3'h1;
        en_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end
    // Mode changed only with strobe low; held 200 ns past the rise
    task automatic switch_mode(input logic [2:0] m);
        @(posedge clk_i);
        en_n_o <= 1'b0;
        @(posedge clk_i);
        mode_o <= m;
        repeat (500) @(posedge clk_i);
        en_n_o <= 1'b1;
        repeat (50) @(posedge clk_i);
    endtask
    // Misbehaviour on command: pins moved while strobe high
    task automatic poke_mode(input logic [2:0] m);
        @(posedge clk_i);
        mode_o <= m;
    endtask
    task automatic frame(input logic rw, input logic [4:0] a, input logic [7:0] wd, output logic [7:0] rd);
        logic [14:0] word;
        word = {1'b0, rw, a, wd};
        rd = 8'h00;
        @(posedge clk_i);
        en_n_o <= 1'b0;
        for (int i = 14; i >= 0; i--) begin
            repeat (4) @(posedge clk_i);
            si_o <= word[i];
            repeat (4) @(posedge clk_i);
            sck_o <= 1'b1;
            if (i < 8) begin
                rd[i] = so_i;
            end
            repeat (4) @(posedge clk_i);
            sck_o <= 1'b0;
        end
        // Frame strobe also switches mode, so keep the full low time
        repeat (380) @(posedge clk_i);
        en_n_o <= 1'b1;
        si_o <= ~si_o;
        repeat (50) @(posedge clk_i);
    endtask
endmodule

// ### tmc_top_tb.sv
// Purpose: Self-checking bench for tmc_top
// Assumes: Host model owns all pin timing
// Notes: Values in 100 Hz and 10 Hz units
module tmc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] mode_pin, mode_out;
    logic en_n, sck, si, so, so_oe, xosc, synth, bb, rx, tx, stepped;
    logic [11:0] bb_bw;
    logic [9:0] hpf;
    logic [7:0] rd;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    int oe_cycles = 0;
    // Stepped order from standby toward receive and transmit; 101 never sent
    logic [2:0] seq [9] = '{3'h2, 3'h3, 3'h4, 3'h1, 3'h6, 3'h7, 3'h1, 3'h0, 3'h1};
    logic [4:0] en_tab [8] = '{5'h00, 5'h10, 5'h14, 5'h1C, 5'h1E, 5'h10, 5'h18, 5'h19};
    logic [11:0] bw_tab [8] = '{12'h064, 12'h0C8, 12'h190, 12'h7D0, 12'h08F, 12'h11D, 12'h29B, 12'h3E8};
    logic [9:0] hpf_tab [8] = '{10'h042, 10'h094, 10'h0AF, 10'h0C4, 10'h0FF, 10'h14E, 10'h1FF, 10'h3FC};
    always #2 clk = ~clk;
    tmc_top tmc_top_i (.CLK_SYS_I(clk), .RST_N_I(rst_n), .MODE_I(mode_pin), .EN_N_I(en_n), .SCK_I(sck),
        .SI_I(si), .SO_O(so), .SO_OE_O(so_oe), .MODE_O(mode_out), .XOSC_EN_O(xosc), .SYNTH_EN_O(synth),
        .BASEBAND_EN_O(bb), .RX_EN_O(rx), .TX_EN_O(tx), .STEPPED_SEQ_O(stepped), .BB_BW_O(bb_bw),
        .HPF_CUTOFF_O(hpf));
    tmc_host_model tmc_host_model_i (.clk_i(clk), .so_i(so), .mode_o(mode_pin), .en_n_o(en_n),
        .sck_o(sck), .si_o(si));
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        tmc_host_model_i.frame(1'b0, a, d, rd);
    endtask
    task automatic check_defaults();
        check("mode", {9'h000, mode_out}, 12'h001);
        check("enables", {7'h00, xosc, synth, bb, rx, tx}, 12'h010);
        check("stepped", {11'h000, stepped}, 12'h001);
        check("bandwidth", bb_bw, 12'h064);
        check("cutoff", {2'h0, hpf}, 12'h042);
    endtask
    // Hang guard: whole run needs about 20000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            conclude();
        end
    end
    // Cycles with the read data pin driven
    always @(posedge clk) begin
        if (so_oe === 1'b1) begin
            oe_cycles++;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check_defaults();
        tmc_host_model_i.poke_mode(3'h7);
        repeat (20) @(posedge clk);
        check("ignored pins", {9'h000, mode_out}, 12'h001);
        tmc_host_model_i.poke_mode(3'h1);
        for (int k = 0; k < 9; k++) begin
            tmc_host_model_i.switch_mode(seq[k]);
            check("mode", {9'h000, mode_out}, {9'h000, seq[k]});
            check("enables", {7'h00, xosc, synth, bb, rx, tx}, {7'h00, en_tab[seq[k]]});
        end
        for (int m = 0; m < 2; m++) begin
            wr(5'h13, {5'h00, m[0], 2'h0});
            for (int c = 0; c < 4; c++) begin
                wr(5'h1D, {6'h00, c[1:0]});
                check("bandwidth", bb_bw, bw_tab[m * 4 + c]);
            end
        end
        check("stepped", {11'h000, stepped}, 12'h001);
        wr(5'h1D, 8'h04);
        check("stepped", {11'h000, stepped}, 12'h000);
        for (int c = 0; c < 8; c++) begin
            wr(5'h16, {2'h0, c[2:0], 3'h0});
            check("cutoff", {2'h0, hpf}, {2'h0, hpf_tab[c]});
        end
        check("no drive on write", {11'h000, oe_cycles == 0}, 12'h001);
        tmc_host_model_i.frame(1'b1, 5'h16, 8'h00, rd);
        check("cutoff readback", {4'h0, rd}, 12'h038);
        check("drive released", {11'h000, so_oe}, 12'h000);
        check("drive during read", {11'h000, oe_cycles > 0}, 12'h001);
        tmc_host_model_i.frame(1'b1, 5'h13, 8'h00, rd);
        check("map readback", {4'h0, rd}, 12'h004);
        tmc_host_model_i.frame(1'b1, 5'h02, 8'h00, rd);
        check("unmapped read", {4'h0, rd}, 12'h000);
        tmc_host_model_i.frame(1'b1, 5'h1E, 8'h00, rd);
        check("mode readback", {4'h0, rd}, 12'h001);
        tmc_host_model_i.frame(1'b1, 5'h1D, 8'h00, rd);
        check("boost readback", {4'h0, rd}, 12'h004);
        // Low cut-off kept below the deviation limit for normal use
        wr(5'h16, 8'h08);
        check("cutoff", {2'h0, hpf}, 12'h094);
        // Mid-run reset must restore every default
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check_defaults();
        conclude();
    end
endmodule
